// *** src/ctl_defines.svh ***
// register offsets, field positions, reset values and timing constants
// assumes inclusion by bare name from the design files
`ifndef CTL_DEFINES_SVH
`define CTL_DEFINES_SVH
`define CTL_ADDR_W          8
`define CTL_OFF_PIN_CFG     8'h6B
`define CTL_OFF_SOFT_TRIG   8'h6C
`define CTL_OFF_LP_CFG      8'h6E
`define CTL_OFF_BG_CFG      8'h60
`define CTL_OFF_STATUS      8'h72
`define CTL_LP_RESET        8'h88
`define CTL_SOFT_RESET      8'h01
`define CTL_PIN_RESET       8'h00
`define CTL_BG_RESET        8'h00
`define CTL_SLEEP_MSB       7
`define CTL_SLEEP_LSB       5
`define CTL_WAKE_MSB        4
`define CTL_WAKE_LSB        3
`define CTL_TRIGWAKE_BIT    1
`define CTL_LPEN_BIT        0
`define CTL_UNIT_SHIFT      8
`define CTL_CNT_W           42
`define CTL_SLEEP0_LEN      42'h900
`endif

// *** src/ctl_pkg.sv ***
// types shared by the calibration trigger and sleep timer
// assumes nothing beyond a SystemVerilog compiler
package ctl_pkg;
    typedef enum logic [3:0] {
        CTL_IDLE  = 4'b0001,
        CTL_SLEEP = 4'b0010,
        CTL_WAKE  = 4'b0100,
        CTL_CAL   = 4'b1000
    } ctl_state_e;
    typedef logic [41:0] ctl_count_t;
endpackage : ctl_pkg

// *** src/ctl_interval.sv ***
// interval length lookup: (2^k + 1) x 256 clock periods from a 3-bit code
// assumes a 42-bit counter
`timescale 1ns/1ps
`include "ctl_defines.svh"
module ctl_interval #(
    parameter bit IS_WAKE = 1'b0
) (
    input  wire logic [2:0]             code,
    output ctl_pkg::ctl_count_t         length
);
    logic [5:0] k;
    always_comb begin
        if (IS_WAKE) begin
            case (code[1:0])
                2'h0:    k = 6'h21;
                2'h1:    k = 6'h12;
                2'h2:    k = 6'h15;
                default: k = 6'h18;
            endcase
        end else begin
            case (code)
                3'h0:    k = 6'h03;
                3'h1:    k = 6'h0F;
                3'h2:    k = 6'h12;
                3'h3:    k = 6'h15;
                3'h4:    k = 6'h18;
                3'h5:    k = 6'h1B;
                3'h6:    k = 6'h1E;
                default: k = 6'h21;
            endcase
        end
        // (2^k + 1) << 8, fits 42 bits for k up to 33
        length = ((ctl_pkg::ctl_count_t'(1) << k) + ctl_pkg::ctl_count_t'(1))
                 << `CTL_UNIT_SHIFT;
    end
endmodule : ctl_interval

// *** src/ctl_lowpower_cal.sv ***
// calibration trigger select and low-power sleep/wake timer, Avalon-MM slave
// assumes one clock (sampling clock), async active-high reset, sync pin
//
// Overview of operation
// - soft trigger bit 0, resets to one
// - soft bit used only when select zero
// - lowpower config field layout, reset 0x88
// - sleep select used when enabled, untriggered
// - sleep length (2^k+1) x 256 clocks
// - sleep select resets to code four
// - select picks soft bit or pin
// - triggered mode sleeps until trigger low
// - lowpower needs background enable, resets off
// - wake settle (2^k+1) x 256, reset k18
`timescale 1ns/1ps
`include "ctl_defines.svh"
module ctl_lowpower_cal #(
    parameter int CNT_W = `CTL_CNT_W
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    input  wire logic        calibration_trigger_pin,
    input  wire logic        core_idle,
    output logic             calibration_trigger,
    output logic             core_sleep,
    output logic             calibration_start
);
    // elaboration check: the longest interval needs the full counter
    if (CNT_W < `CTL_CNT_W) begin : g_cnt_w_check
        $error("counter too narrow for longest interval");
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic [7:0] lp_cfg_reg, lp_cfg_next;
    logic [7:0] soft_reg, soft_next;
    logic [7:0] pin_reg, pin_next;
    logic [7:0] bg_reg, bg_next;
    logic       ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        err_reg, err_next;
    logic        hit;
    logic [7:0]  rmux;
    ctl_pkg::ctl_state_e state_reg, state_next;

    // one wait cycle: request taken, answer at next edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_response    = err_reg ? 2'h2 : 2'h0;

    always_comb begin
        hit = 1'b1;
        case (avs_address)
            `CTL_OFF_LP_CFG:    rmux = lp_cfg_reg;
            `CTL_OFF_SOFT_TRIG: rmux = soft_reg;
            `CTL_OFF_PIN_CFG:   rmux = pin_reg;
            `CTL_OFF_BG_CFG:    rmux = bg_reg;
            `CTL_OFF_STATUS:    rmux = {4'h0, state_reg};
            default: begin
                rmux = 8'h00;
                hit  = 1'b0;
            end
        endcase
    end

    always_comb begin
        lp_cfg_next = lp_cfg_reg;
        soft_next   = soft_reg;
        pin_next    = pin_reg;
        bg_next     = bg_reg;
        ack_next    = (avs_read | avs_write) & ~ack_reg;
        rdata_next  = rdata_reg;
        err_next    = err_reg;
        if ((avs_read | avs_write) & ~ack_reg) begin
            err_next   = ~hit;
            rdata_next = avs_read ? {24'h000000, rmux} : 32'h00000000;
            if (avs_write && avs_byteenable[0]) begin
                case (avs_address)
                    // reserved bit 2 stays writable as stored
                    `CTL_OFF_LP_CFG:    lp_cfg_next = avs_writedata[7:0];
                    `CTL_OFF_SOFT_TRIG: soft_next   = avs_writedata[7:0];
                    `CTL_OFF_PIN_CFG:   pin_next    = avs_writedata[7:0];
                    `CTL_OFF_BG_CFG:    bg_next     = avs_writedata[7:0];
                    default:            ;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lp_cfg_reg <= `CTL_LP_RESET;
            soft_reg   <= `CTL_SOFT_RESET;
            pin_reg    <= `CTL_PIN_RESET;
            bg_reg     <= `CTL_BG_RESET;
            ack_reg    <= 1'b0;
            rdata_reg  <= 32'h00000000;
            err_reg    <= 1'b0;
        end else begin
            lp_cfg_reg <= lp_cfg_next;
            soft_reg   <= soft_next;
            pin_reg    <= pin_next;
            bg_reg     <= bg_next;
            ack_reg    <= ack_next;
            rdata_reg  <= rdata_next;
            err_reg    <= err_next;
        end
    end

    // ************************************************************
    // trigger source and sleep timer
    // ************************************************************
    logic lp_active, trig_wake, trig_next, trig_reg;
    ctl_pkg::ctl_count_t sleep_len, wake_len;
    logic [CNT_W-1:0] cnt_reg, cnt_next;

    // only meaningful with background calibration on
    assign lp_active = lp_cfg_reg[`CTL_LPEN_BIT] & bg_reg[1];
    assign trig_wake = lp_cfg_reg[`CTL_TRIGWAKE_BIT];
    assign trig_next = pin_reg[0] ? calibration_trigger_pin
                                  : soft_reg[0];

    ctl_interval #(.IS_WAKE(1'b0)) u_sleep_len (
        .code   (lp_cfg_reg[`CTL_SLEEP_MSB:`CTL_SLEEP_LSB]),
        .length (sleep_len)
    );

    ctl_interval #(.IS_WAKE(1'b1)) u_wake_len (
        .code   ({1'b0, lp_cfg_reg[`CTL_WAKE_MSB:`CTL_WAKE_LSB]}),
        .length (wake_len)
    );

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + CNT_W'(1);
        case (state_reg)
            ctl_pkg::CTL_IDLE: begin
                cnt_next = '0;
                if (lp_active && core_idle) begin
                    state_next = ctl_pkg::CTL_SLEEP;
                end
            end
            ctl_pkg::CTL_SLEEP: begin
                if (!lp_active) begin
                    state_next = ctl_pkg::CTL_IDLE;
                    cnt_next   = '0;
                end else if (trig_wake ? !trig_reg
                             : (cnt_reg >= CNT_W'(sleep_len) - CNT_W'(1))) begin
                    state_next = ctl_pkg::CTL_WAKE;
                    cnt_next   = '0;
                end
            end
            ctl_pkg::CTL_WAKE: begin
                // settle before calibrating, else core not stable
                if (cnt_reg >= CNT_W'(wake_len) - CNT_W'(1)) begin
                    state_next = ctl_pkg::CTL_CAL;
                    cnt_next   = '0;
                end
            end
            ctl_pkg::CTL_CAL: begin
                state_next = ctl_pkg::CTL_IDLE;
                cnt_next   = '0;
            end
            default: begin
                state_next = ctl_pkg::CTL_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= ctl_pkg::CTL_IDLE;
            cnt_reg   <= '0;
            trig_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            trig_reg  <= trig_next;
        end
    end

    assign calibration_trigger = trig_reg;
    assign core_sleep          = (state_reg == ctl_pkg::CTL_SLEEP);
    assign calibration_start   = (state_reg == ctl_pkg::CTL_CAL);

    // ************************************************************
    // assertions
    // ************************************************************
    property p_soft_src;
        @(posedge clock) disable iff (reset)
        !pin_reg[0] |=> calibration_trigger == $past(soft_reg[0]);
    endproperty
    a_soft_src: assert property (p_soft_src) else $error("soft trigger not used");

    property p_pin_src;
        @(posedge clock) disable iff (reset)
        pin_reg[0] |=> calibration_trigger == $past(calibration_trigger_pin);
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("pin not used");

    property p_lp_gate;
        @(posedge clock) disable iff (reset)
        !bg_reg[1] && state_reg == ctl_pkg::CTL_IDLE |=> state_reg == ctl_pkg::CTL_IDLE;
    endproperty
    a_lp_gate: assert property (p_lp_gate) else $error("sleep without background");

    property p_trig_hold;
        @(posedge clock) disable iff (reset)
        core_sleep && trig_wake && trig_reg && lp_active |=> core_sleep;
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("woke with trigger high");

    property p_trig_wake;
        @(posedge clock) disable iff (reset)
        core_sleep && trig_wake && !trig_reg && lp_active |=> state_reg == ctl_pkg::CTL_WAKE;
    endproperty
    a_trig_wake: assert property (p_trig_wake) else $error("no wake on low trigger");

    property p_sleep_restart;
        @(posedge clock) disable iff (reset)
        $rose(core_sleep) |-> cnt_reg == '0;
    endproperty
    a_sleep_restart: assert property (p_sleep_restart) else $error("counter not restarted");

    property p_sleep_len;
        @(posedge clock) disable iff (reset)
        core_sleep && !trig_wake && lp_active && lp_cfg_reg[7:5] == 3'h0
        && cnt_reg < CNT_W'(`CTL_SLEEP0_LEN) - CNT_W'(1) |=> core_sleep;
    endproperty
    a_sleep_len: assert property (p_sleep_len) else $error("short sleep ended early");

    property p_sleep_end;
        @(posedge clock) disable iff (reset)
        core_sleep && !trig_wake && lp_active && lp_cfg_reg[7:5] == 3'h0
        && cnt_reg == CNT_W'(`CTL_SLEEP0_LEN) - CNT_W'(1) |=> state_reg == ctl_pkg::CTL_WAKE;
    endproperty
    a_sleep_end: assert property (p_sleep_end) else $error("short sleep overran");

    property p_cal_pulse;
        @(posedge clock) disable iff (reset)
        calibration_start |=> !calibration_start;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("start not one cycle");
endmodule : ctl_lowpower_cal

// *** bench/tb.sv ***
// self-checking bench for the calibration trigger select and sleep timer
// assumes ctl_defines.svh on the include path and the design compiled first
`timescale 1ns/1ps
`include "ctl_defines.svh"
module tb;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [1:0]  resp;
    } ctl_row_s;
    logic        clock;
    logic        reset;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        calibration_trigger_pin;
    logic        core_idle;
    logic        calibration_trigger;
    logic        core_sleep;
    logic        calibration_start;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          fail_count;
    int          check_count;
    int          cycles;
    int          sleep_cycles;
    int          n;
    ctl_row_s    rows [6];
    ctl_lowpower_cal i_ctl_lowpower_cal (
        .clock                   (clock),
        .reset                   (reset),
        .avs_address             (avs_address),
        .avs_read                (avs_read),
        .avs_write               (avs_write),
        .avs_writedata           (avs_writedata),
        .avs_byteenable          (avs_byteenable),
        .avs_readdata            (avs_readdata),
        .avs_waitrequest         (avs_waitrequest),
        .avs_response            (avs_response),
        .calibration_trigger_pin (calibration_trigger_pin),
        .core_idle               (core_idle),
        .calibration_trigger     (calibration_trigger),
        .core_sleep              (core_sleep),
        .calibration_start       (calibration_start)
    );
    // ****************************************
    // helpers
    // ****************************************
    task stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step
    // read right after the edge, outputs still hold what that edge sampled
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = avs_readdata;
        rs = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task wait_sleep();
        n = 0;
        while (core_sleep !== 1'b1 && n < 20) begin
            step(1);
            n = n + 1;
        end
    endtask : wait_sleep
    task do_reset();
        @(posedge clock);
        reset <= 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        step(1);
    endtask : do_reset
    // ****************************************
    // clock, timeout
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // full run is about 5500 cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (core_sleep === 1'b1) begin
            sleep_cycles = sleep_cycles + 1;
        end
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        calibration_trigger_pin = 1'b1;
        core_idle = 1'b0;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        sleep_cycles = 0;
        rows[0] = '{8'h6E, 32'h00000088, 2'h0};
        rows[1] = '{8'h6C, 32'h00000001, 2'h0};
        rows[2] = '{8'h6B, 32'h00000000, 2'h0};
        rows[3] = '{8'h60, 32'h00000000, 2'h0};
        rows[4] = '{8'h72, 32'h00000001, 2'h0};
        rows[5] = '{8'h50, 32'h00000000, 2'h2};
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        step(1);
        chk(calibration_trigger, 1'b1);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].addr, 8'h00);
            chk(rd, rows[i].data);
            chk(rs, rows[i].resp);
        end
        // pin ignored while software source selected
        calibration_trigger_pin <= 1'b0;
        step(3);
        chk(calibration_trigger, 1'b1);
        bus(1'b1, 8'h6C, 8'h00);
        step(2);
        chk(calibration_trigger, 1'b0);
        @(posedge clock);
        avs_byteenable <= 4'hE;
        bus(1'b1, 8'h6C, 8'h01);
        avs_byteenable <= 4'hF;
        step(2);
        chk(calibration_trigger, 1'b0);
        bus(1'b1, 8'h6B, 8'h01);
        calibration_trigger_pin <= 1'b1;
        step(3);
        chk(calibration_trigger, 1'b1);
        @(posedge clock);
        calibration_trigger_pin <= 1'b0;
        bus(1'b1, 8'h6C, 8'h01);
        step(2);
        chk(calibration_trigger, 1'b0);
        bus(1'b1, 8'h6B, 8'h00);
        step(2);
        chk(calibration_trigger, 1'b1);
        bus(1'b1, 8'h50, 8'hFF);
        chk(rs, 2'h2);
        // shortest sleep code, needs background enable
        core_idle <= 1'b1;
        bus(1'b1, 8'h6E, 8'h09);
        step(20);
        chk(core_sleep, 1'b0);
        bus(1'b0, 8'h6E, 8'h00);
        chk(rd, 32'h00000009);
        sleep_cycles = 0;
        bus(1'b1, 8'h60, 8'h02);
        wait_sleep();
        while (core_sleep === 1'b1 && n < 5000) begin
            n = n + 1;
            step(1);
        end
        chk(sleep_cycles, 32'd2304);
        chk(calibration_start, 1'b0);
        // wake settle is far too long to run out here
        bus(1'b0, 8'h72, 8'h00);
        chk(rd, 32'h00000004);
        do_reset();
        chk(core_sleep, 1'b0);
        chk(calibration_trigger, 1'b1);
        bus(1'b0, 8'h6E, 8'h00);
        chk(rd, 32'h00000088);
        core_idle <= 1'b0;
        bus(1'b1, 8'h60, 8'h02);
        // sleep code 0 with triggered wake: the short interval must not end sleep
        bus(1'b1, 8'h6E, 8'h0B);
        step(5);
        chk(core_sleep, 1'b0);
        @(posedge clock);
        core_idle <= 1'b1;
        wait_sleep();
        step(3000);
        chk(core_sleep, 1'b1);
        bus(1'b1, 8'h6C, 8'h00);
        step(10);
        chk(core_sleep, 1'b0);
        chk(calibration_start, 1'b0);
        bus(1'b0, 8'h72, 8'h00);
        chk(rd, 32'h00000004);
        // leave software at the recommended sleep code and idle trigger
        bus(1'b1, 8'h6E, 8'h88);
        bus(1'b1, 8'h6C, 8'h01);
        bus(1'b0, 8'h6E, 8'h00);
        chk(rd, 32'h00000088);
        step(2);
        chk(calibration_trigger, 1'b1);
        stop_test();
    end
endmodule : tb
